// [hdl/iesp_core.sv]
// iesp_core: target-side engine of a 1 Mbit serial eeprom with its array
// assumes sda is open drain with an outside pull-up and scl comes from the master
//
// How it works
// - data bits are taken on the rising serial clock edge
// - select byte arrives msb first; top four bits must equal the type id
// - answer only when both chip-enable bits equal the chip-enable pins
// - last select bit: one means read, zero means write
// - matched select gets an ack in the ninth bit; mismatch returns to standby
// - write select is acked, then two acked address bytes, then data bytes
// - write-inhibit high from start to address end: data nacked, memory untouched
// - 17-bit address: top bit in select byte, then high and low bytes
// - programming starts only on a stop right after a data ack
// - after programming the counter points past the last byte modified
// - while programming, sda stays released and all requests are ignored
// - page write stays in one 256-byte row; only low 8 address bits count
// - reads correct any single bit error in each 4-byte word
// - any write reprograms its whole 4-byte word with fresh check bits
// - reads work whatever the write-inhibit level
// - random read: write select, address, repeated start, read select
// - read select alone outputs the byte at the counter, then increments
// - master ack gives the next byte; counter wraps past the top to zero
// - read byte not acked by the master ends the transfer into standby
// - start is sda falling with scl high; traffic before a start is ignored
// - stop is sda rising with scl high; it ends the transfer
// - unconnected chip-enable and write-inhibit inputs read as low
module iesp_core #(
    parameter logic [3:0] DEV_TYPE    = iesp_pkg::DEV_TYPE_DEF,
    parameter int         PROG_CYCLES = iesp_pkg::PROG_CYCLES_DEF
) (
    // system
    input  wire logic clk,
    input  wire logic reset_n,
    // serial link
    input  wire logic scl_clk,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // straps
    input  wire logic chip_sel_pin_low,
    input  wire logic chip_sel_pin_high,
    input  wire logic write_inhibit_in,
    // status
    output logic      prog_busy
);
    import iesp_pkg::*;

    localparam logic [31:0] PROG_LAST = 32'(PROG_CYCLES - 1);

    // ********************************
    // error correction
    // ********************************
    // hamming code over positions 1..38, check bits at the powers of two
    function automatic logic [CW_W-1:0] ecc_enc(input logic [31:0] d);
        logic [CW_W-1:0] cw;
        int              k;
        cw = '0;
        k = 0;
        for (int p = 1; p <= CW_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                cw[p-1] = d[k];
                k++;
            end
        end
        for (int i = 0; i < ECC_W; i++) begin
            for (int p = 1; p <= CW_W; p++) begin
                if (((p >> i) & 1) == 1 && (p & (p - 1)) != 0) begin
                    cw[(1 << i) - 1] = cw[(1 << i) - 1] ^ cw[p-1];
                end
            end
        end
        return cw;
    endfunction : ecc_enc

    // a syndrome beyond the word means several errors: passed through as is
    function automatic logic [31:0] ecc_fix(input logic [CW_W-1:0] cw_in);
        logic [CW_W-1:0] cw;
        logic [5:0]      syn;
        logic [31:0]     d;
        int              k;
        cw = cw_in;
        syn = '0;
        d = '0;
        k = 0;
        for (int p = 1; p <= CW_W; p++) begin
            if (cw[p-1]) begin
                syn = syn ^ 6'(p);
            end
        end
        if (syn != 6'h00 && int'(syn) <= CW_W) begin
            cw[syn - 6'h01] = ~cw[syn - 6'h01];
        end
        for (int p = 1; p <= CW_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                d[k] = cw[p-1];
                k++;
            end
        end
        return d;
    endfunction : ecc_fix

    // ********************************
    // link domain
    // ********************************
    logic link_bit_r;
    logic link_tog_r;

    // the bit stays put for a whole scl period, so the toggle carries it
    always_ff @(posedge scl_clk or negedge reset_n) begin
        if (!reset_n) begin
            link_bit_r <= 1'b0;
            link_tog_r <= 1'b0;
        end else begin
            link_bit_r <= sda_in;
            link_tog_r <= ~link_tog_r;
        end
    end

    // ********************************
    // crossings and pin filters
    // ********************************
    logic [2:0] tog_s_r;
    logic [4:0] pin_raw;
    logic [4:0] pin_s1_r;
    logic [4:0] pin_s2_r;
    logic [4:0] pin_s3_r;
    logic [4:0] pin_f_r;
    logic [4:0] pin_fv;
    iesp_pins_t pin_f;
    iesp_pins_t pin_fr;

    // floating strap pins are pulled low at the pad, so idle reads zero
    assign pin_raw = {write_inhibit_in, chip_sel_pin_high, chip_sel_pin_low,
                      sda_in, scl_clk};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tog_s_r  <= 3'h0;
            pin_s1_r <= PINS_IDLE;
            pin_s2_r <= PINS_IDLE;
            pin_s3_r <= PINS_IDLE;
            pin_f_r  <= PINS_IDLE;
        end else begin
            tog_s_r  <= {tog_s_r[1:0], link_tog_r};
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_f_r  <= pin_fv;
        end
    end

    generate
        for (genvar i = 0; i < 5; i++) begin : g_filt
            assign pin_fv[i] = (pin_s2_r[i] == pin_s3_r[i]) ? pin_s3_r[i] : pin_f_r[i];
        end
    endgenerate

    assign pin_f  = pin_fv;
    assign pin_fr = pin_f_r;

    // ********************************
    // bus events and decode
    // ********************************
    iesp_state_t     state_r;
    logic [3:0]      bit_cnt_r;
    logic [7:0]      shift_r;
    logic [7:0]      tx_r;
    logic [16:0]     addr_r;
    logic [16:0]     prog_addr_r;
    logic            sel_rd_r;
    logic            wi_seen_r;
    logic            ack_done_r;
    logic            stop_win_r;
    logic            next_oe_r;
    logic            oe_pend_r;
    logic            sda_oe_r;
    logic            busy_r;
    logic [255:0]    mask_r;
    logic [6:0]      prog_idx_r;
    logic [31:0]     prog_cnt_r;
    logic [7:0]      page_r [0:PAGE_BYTES-1];
    logic [CW_W-1:0] mem_r [0:WORDS-1];

    wire        bit_evt  = tog_s_r[2] ^ tog_s_r[1];
    wire        scl_hi   = pin_f.scl & pin_fr.scl;
    wire        scl_low  = ~pin_f.scl;
    wire        live     = (state_r != ST_PROG);
    wire        start_ok = live & scl_hi & pin_fr.sda & ~pin_f.sda;
    wire        stop_ok  = live & scl_hi & ~pin_fr.sda & pin_f.sda;
    wire [7:0]  byte_in  = {shift_r[6:0], link_bit_r};
    iesp_sel_t  sel;
    assign sel = byte_in;
    wire        sel_match = (sel.type_id == DEV_TYPE)
                          & (sel.ce_high == pin_f.ce_high)
                          & (sel.ce_low == pin_f.ce_low);
    wire        at_end   = bit_evt & (bit_cnt_r == BIT_LAST);
    wire        wr_byte  = at_end & (state_r == ST_WDATA) & ~wi_seen_r;
    wire        prog_go  = stop_ok & (state_r == ST_WDATA)
                         & (ack_done_r | stop_win_r) & (|mask_r);
    wire        prog_done = (state_r == ST_PROG) & prog_idx_r[6]
                          & (prog_cnt_r >= PROG_LAST);

    // read side ignores write-inhibit entirely
    wire [31:0] rd_word  = ecc_fix(mem_r[addr_r[16:2]]);
    wire [7:0]  rd_byte  = rd_word[{addr_r[1:0], 3'b000} +: 8];

    // program side: merge buffered bytes into the stored word
    wire [14:0] prog_word = {prog_addr_r[16:8], prog_idx_r[5:0]};
    wire [31:0] cur_word  = ecc_fix(mem_r[prog_word]);
    wire        word_dirty = |mask_r[{prog_idx_r[5:0], 2'b00} +: 4];
    logic [31:0] merged;

    generate
        for (genvar j = 0; j < WORD_BYTES; j++) begin : g_lane
            wire [7:0] lane_idx = {prog_idx_r[5:0], 2'(j)};
            assign merged[j*8 +: 8] = mask_r[lane_idx] ? page_r[lane_idx]
                                                       : cur_word[j*8 +: 8];
        end
    endgenerate

    // ********************************
    // protocol control
    // ********************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r    <= ST_IDLE;
            bit_cnt_r  <= 4'h0;
            shift_r    <= 8'h00;
            tx_r       <= 8'h00;
            addr_r     <= ADDR_RST;
            sel_rd_r   <= 1'b0;
            ack_done_r <= 1'b0;
            stop_win_r <= 1'b0;
            next_oe_r  <= 1'b0;
        end else if (!live) begin
            if (prog_done) begin
                state_r <= ST_IDLE;
                addr_r  <= prog_addr_r;
            end
        end else if (stop_ok) begin
            state_r    <= prog_go ? ST_PROG : ST_IDLE;
            bit_cnt_r  <= 4'h0;
            ack_done_r <= 1'b0;
            stop_win_r <= 1'b0;
            next_oe_r  <= 1'b0;
        end else if (start_ok) begin
            // a start anywhere, even mid-byte, restarts select decoding
            state_r    <= ST_SEL;
            bit_cnt_r  <= 4'h0;
            ack_done_r <= 1'b0;
            stop_win_r <= 1'b0;
            next_oe_r  <= 1'b0;
        end else if (bit_evt && state_r != ST_IDLE) begin
            // a stop is only good in the slot right after a data ack
            stop_win_r <= ack_done_r;
            ack_done_r <= 1'b0;
            if (bit_cnt_r == BIT_ACK) begin
                bit_cnt_r <= 4'h0;
                next_oe_r <= 1'b0;
                case (state_r)
                    ST_SEL: begin
                        if (sel_rd_r) begin
                            state_r   <= ST_RDATA;
                            tx_r      <= rd_byte;
                            next_oe_r <= ~rd_byte[7];
                            addr_r    <= addr_r + 17'h00001;
                        end else begin
                            state_r <= ST_ADDR_HI;
                        end
                    end
                    ST_ADDR_HI: begin
                        state_r <= ST_ADDR_LO;
                    end
                    ST_ADDR_LO: begin
                        state_r <= ST_WDATA;
                    end
                    ST_WDATA: begin
                        ack_done_r <= ~wi_seen_r;
                    end
                    ST_RDATA: begin
                        if (!link_bit_r) begin
                            tx_r      <= rd_byte;
                            next_oe_r <= ~rd_byte[7];
                            addr_r    <= addr_r + 17'h00001;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end else begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
                shift_r   <= byte_in;
                next_oe_r <= 1'b0;
                if (state_r == ST_RDATA && bit_cnt_r != BIT_LAST) begin
                    next_oe_r <= ~tx_r[6];
                    tx_r      <= {tx_r[6:0], 1'b0};
                end
                if (bit_cnt_r == BIT_LAST) begin
                    case (state_r)
                        ST_SEL: begin
                            if (sel_match) begin
                                next_oe_r <= 1'b1;
                                sel_rd_r  <= sel.rd;
                                if (!sel.rd) begin
                                    addr_r[16] <= sel.a_top;
                                end
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end
                        ST_ADDR_HI: begin
                            addr_r[15:8] <= byte_in;
                            next_oe_r    <= 1'b1;
                        end
                        ST_ADDR_LO: begin
                            addr_r[7:0] <= byte_in;
                            next_oe_r   <= 1'b1;
                        end
                        ST_WDATA: begin
                            next_oe_r <= ~wi_seen_r;
                            if (!wi_seen_r) begin
                                addr_r[7:0] <= addr_r[7:0] + 8'h01;
                            end
                        end
                        default: begin
                            next_oe_r <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // ********************************
    // sda drive
    // ********************************
    // changes land only while scl is low, so no false start or stop is made
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oe_pend_r <= 1'b0;
            sda_oe_r  <= 1'b0;
        end else begin
            if (start_ok || stop_ok) begin
                oe_pend_r <= 1'b0;
            end else if (bit_evt) begin
                oe_pend_r <= 1'b1;
            end else if (scl_low) begin
                oe_pend_r <= 1'b0;
            end
            if (!live || state_r == ST_IDLE || start_ok || stop_ok) begin
                sda_oe_r <= 1'b0;
            end else if (scl_low && oe_pend_r) begin
                sda_oe_r <= next_oe_r;
            end
        end
    end

    assign sda_oe  = sda_oe_r;
    assign sda_out = 1'b0;

    // ********************************
    // write-inhibit capture
    // ********************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wi_seen_r <= 1'b0;
        end else if (start_ok) begin
            wi_seen_r <= pin_f.wi;
        end else if ((state_r == ST_SEL || state_r == ST_ADDR_HI
                      || state_r == ST_ADDR_LO) && pin_f.wi) begin
            wi_seen_r <= 1'b1;
        end
    end

    // ********************************
    // page buffer
    // ********************************
    // bytes past the row end wrap and overwrite earlier ones in the buffer
    always_ff @(posedge clk) begin
        if (wr_byte) begin
            page_r[addr_r[7:0]] <= byte_in;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_r <= '0;
        end else if (start_ok || prog_done) begin
            mask_r <= '0;
        end else if (wr_byte) begin
            mask_r[addr_r[7:0]] <= 1'b1;
        end
    end

    // ********************************
    // programming cycle
    // ********************************
    // one word per clock over the row, then wait out the cycle time
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prog_idx_r  <= 7'h00;
            prog_cnt_r  <= 32'h00000000;
            prog_addr_r <= ADDR_RST;
            busy_r      <= 1'b0;
        end else if (prog_go) begin
            prog_idx_r  <= 7'h00;
            prog_cnt_r  <= 32'h00000000;
            prog_addr_r <= addr_r;
            busy_r      <= 1'b1;
        end else if (!live) begin
            prog_cnt_r <= prog_cnt_r + 32'h00000001;
            if (!prog_idx_r[6]) begin
                prog_idx_r <= prog_idx_r + 7'h01;
            end
            if (prog_done) begin
                busy_r <= 1'b0;
            end
        end
    end

    assign prog_busy = busy_r;

    // array starts erased, every byte all ones
    initial begin
        for (int w = 0; w < WORDS; w++) begin
            mem_r[w] = ecc_enc(ERASED_WORD);
        end
    end

    // plain always: the erased fill above also writes the array, which always_ff forbids
    always @(posedge clk) begin
        if (!live && !prog_idx_r[6] && word_dirty) begin
            mem_r[prog_word] <= ecc_enc(merged);
        end
    end

endmodule : iesp_core

// [hdl/iesp_pkg.sv]
// iesp_pkg: constants and types of the serial eeprom target engine
// assumes a 40 MHz system clock; the serial clock is a domain of its own
package iesp_pkg;

    // ********************************
    // sizes
    // ********************************
    localparam int ADDR_W     = 17;
    localparam int WORD_BYTES = 4;
    localparam int PAGE_BYTES = 256;
    localparam int ECC_W      = 6;
    localparam int CW_W       = 38;
    localparam int WORDS      = (2 ** ADDR_W) / WORD_BYTES;
    localparam int ROW_WORDS  = PAGE_BYTES / WORD_BYTES;

    // ********************************
    // codes and reset values
    // ********************************
    // arbitrary value, not tied to any real part
    localparam logic [3:0]        DEV_TYPE_DEF = 4'h6;
    localparam logic [3:0]        BIT_LAST     = 4'h7;
    localparam logic [3:0]        BIT_ACK      = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_RST     = 17'h00000;
    localparam logic [31:0]       ERASED_WORD  = 32'hffffffff;
    // scl and sda idle high, straps idle low
    localparam logic [4:0]        PINS_IDLE    = 5'h03;

    // ********************************
    // timing
    // ********************************
    localparam int CLK_PERIOD_NS   = 25;
    localparam int PROG_TIME_US    = 5000;
    localparam int PROG_CYCLES_DEF = PROG_TIME_US * 1000 / CLK_PERIOD_NS;

    // ********************************
    // types
    // ********************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_SEL, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA, ST_RDATA, ST_PROG
    } iesp_state_t;

    typedef struct packed {
        logic wi;
        logic ce_high;
        logic ce_low;
        logic sda;
        logic scl;
    } iesp_pins_t;

    typedef struct packed {
        logic [3:0] type_id;
        logic       ce_high;
        logic       ce_low;
        logic       a_top;
        logic       rd;
    } iesp_sel_t;

endpackage : iesp_pkg

// [sim/iesp_core_assertions.sv]
// iesp_core_assertions: port checks on the serial eeprom target engine
// assumes a bind onto iesp_core; scl is sampled in the clk domain
module iesp_core_assertions #(
    parameter int PROG_CYCLES = 100
) (
    // system
    input wire logic clk,
    input wire logic reset_n,
    // link and straps
    input wire logic scl_clk,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic chip_sel_pin_low,
    input wire logic chip_sel_pin_high,
    input wire logic write_inhibit_in,
    // status
    input wire logic prog_busy
);
    timeunit 1ns;
    timeprecision 100ps;
    import iesp_pkg::*;
    int busy_cnt_r;
    // **********
    // helpers
    // **********
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_cnt_r <= 0;
        end else begin
            busy_cnt_r <= prog_busy ? busy_cnt_r + 1 : 0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence scl_idle;
        scl_clk [*8];
    endsequence
    sequence prog_start;
        $rose(prog_busy);
    endsequence
    // **********
    // checks
    // **********
    a_out_const: assert property (sda_out == 1'b0)
        else $error("sda data value not low");
    a_busy_quiet: assert property (prog_busy |-> !sda_oe)
        else $error("sda driven while programming");
    a_busy_hold: assert property (prog_start |=> prog_busy [*8])
        else $error("programming dropped early");
    a_busy_length: assert property ($fell(prog_busy) |->
        busy_cnt_r >= PROG_CYCLES - 1 && busy_cnt_r <= PROG_CYCLES + 1)
        else $error("programming length wrong");
    a_prog_on_stop: assert property (prog_start |-> scl_clk && sda_in && $past(scl_clk, 4))
        else $error("programming without stop");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_clk, 2))
        else $error("sda changed while scl high");
    a_idle_release: assert property (scl_idle |-> !sda_oe)
        else $error("sda driven on idle bus");
    a_reset_quiet: assert property ($rose(reset_n) |-> !sda_oe && !prog_busy)
        else $error("outputs active after reset");
endmodule : iesp_core_assertions

// [sim/iesp_core_tb.sv]
// iesp_core_tb: self-checking bench of the serial eeprom target engine
// assumes iesp_master as bus master and a pull-up on the sda wire
module iesp_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import iesp_pkg::*;
    localparam int PROG_CYCLES = 100;
    logic        clk, reset_n, scl_clk, m_low, sda_out, sda_oe, prog_busy;
    logic        ce_lo, ce_hi, wi, ok;
    wire         sda_w;
    int          err_count, tests_run;
    logic [9:0]  exp_q[$];
    logic [9:0]  res, exp_e;
    event        res_ev;
    logic [7:0]  mem[logic [16:0]];
    logic [16:0] a, b;
    logic [7:0]  d;
    assign sda_w = !(m_low || (sda_oe && !sda_out));
    iesp_core #(.PROG_CYCLES(PROG_CYCLES)) u_iesp_core (.clk, .reset_n, .scl_clk,
        .sda_in(sda_w), .sda_out, .sda_oe, .chip_sel_pin_low(ce_lo),
        .chip_sel_pin_high(ce_hi), .write_inhibit_in(wi), .prog_busy);
    iesp_master u_iesp_master (.scl(scl_clk), .sda_low(m_low), .sda(sda_w));
    // **********
    // checking
    // **********
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %0t byte %h expected %h", $time, g, e);
        end
    endtask : cmp_byte
    task automatic cmp_bit(input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %0t flag %b expected %b", $time, g, e);
        end
    endtask : cmp_bit
    function automatic logic [7:0] sel(input logic a16, input logic rd);
        return {DEV_TYPE_DEF, ce_hi, ce_lo, a16, rd};
    endfunction : sel
    function automatic logic [7:0] exp_rd(input logic [16:0] x);
        return mem.exists(x) ? mem[x] : ERASED_WORD[7:0];
    endfunction : exp_rd
    task automatic post(input logic [9:0] r);
        res = r;
        -> res_ev;
        #1;
    endtask : post
    task automatic tx(input logic [7:0] v, input logic ea);
        logic ak;
        exp_q.push_back({9'd0, ea});
        u_iesp_master.byte_tx(v, ak);
        post({9'd0, ak});
    endtask : tx
    task automatic rx(input logic [7:0] ev, input logic mack);
        logic [7:0] v;
        exp_q.push_back({2'b10, ev});
        u_iesp_master.byte_rx(mack, v);
        post({2'b10, v});
    endtask : rx
    task automatic busy(input logic eb);
        exp_q.push_back({9'd0, eb});
        post({9'd0, prog_busy});
    endtask : busy
    task automatic wr_addr(input logic [16:0] x);
        u_iesp_master.start();
        tx(sel(x[16], 1'b0), 1'b1);
        tx(x[15:8], 1'b1);
        tx(x[7:0], 1'b1);
    endtask : wr_addr
    task automatic rd_seq(input logic [16:0] x, input int n);
        wr_addr(x);
        u_iesp_master.start();
        tx(sel(x[16], 1'b1), 1'b1);
        for (int k = 0; k < n; k++) begin
            rx(exp_rd(x + 17'(k)), k < n - 1);
        end
        u_iesp_master.stop();
    endtask : rd_seq
    task automatic poll();
        logic ak;
        ak = 1'b0;
        busy(1'b1);
        u_iesp_master.start();
        tx(sel(1'b0, 1'b1), 1'b0);
        for (int i = 0; i < 20 && !ak; i++) begin
            u_iesp_master.start();
            u_iesp_master.byte_tx(sel(1'b0, 1'b1), ak);
        end
        exp_q.push_back(10'd1);
        post({9'd0, ak});
    endtask : poll
    // **********
    // processes
    // **********
    initial begin
        clk = 1'b0;
        forever #12.5 clk = !clk;
    end
    initial begin
        forever begin
            @(res_ev);
            exp_e = exp_q.pop_front();
            if (exp_e[9]) begin
                cmp_byte(exp_e[7:0], res[7:0]);
            end else begin
                cmp_bit(exp_e[0], res[0]);
            end
        end
    end
    initial begin
        #1_000_000;
        err_count++;
        $display("FAIL %0t watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        {reset_n, ce_lo, ce_hi, wi} = 4'h0;
        void'($urandom(32'h10f6));
        repeat (12) @(posedge clk);
        #2 reset_n = 1'b1;
        {ce_hi, ce_lo} = 2'($urandom);
        repeat (8) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            u_iesp_master.start();
            tx({DEV_TYPE_DEF, 2'(i), 2'b00}, 2'(i) == {ce_hi, ce_lo});
        end
        u_iesp_master.start();
        tx({~DEV_TYPE_DEF, ce_hi, ce_lo, 2'b00}, 1'b0);
        u_iesp_master.stop();
        busy(1'b0);
        a = {1'b1, 8'($urandom), 8'h10};
        d = 8'($urandom);
        wr_addr(a);
        tx(d, 1'b1);
        mem[a] = d;
        u_iesp_master.stop();
        poll();
        rx(exp_rd(a + 17'd1), 1'b0);
        u_iesp_master.stop();
        // page write that rolls over inside its row
        b = {a[16:8], 8'hfe};
        wr_addr(b);
        for (int k = 0; k < 4; k++) begin
            d = 8'($urandom);
            tx(d, 1'b1);
            mem[{b[16:8], b[7:0] + 8'(k)}] = d;
        end
        u_iesp_master.stop();
        poll();
        rx(exp_rd({b[16:8], 8'h02}), 1'b0);
        u_iesp_master.stop();
        rd_seq(b, 3);
        rd_seq({b[16:8], 8'h00}, 2);
        rd_seq(a, 4);
        @(posedge clk);
        #2 wi = 1'b1;
        repeat (4) @(posedge clk);
        wr_addr(a);
        tx(~mem[a], 1'b0);
        u_iesp_master.stop();
        busy(1'b0);
        rd_seq(a, 1);
        u_iesp_master.start();
        for (int i = 0; i < 3; i++) begin
            u_iesp_master.bit_io(1'b0, ok);
        end
        rd_seq(a, 2);
        @(posedge clk);
        #2 wi = 1'b0;
        rd_seq(17'h1fffe, 3);
        repeat (10) @(posedge clk);
        tally_and_finish();
    end
endmodule : iesp_core_tb
bind iesp_core iesp_core_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_iesp_core_assertions (
    .clk, .reset_n, .scl_clk, .sda_in, .sda_out, .sda_oe, .chip_sel_pin_low,
    .chip_sel_pin_high, .write_inhibit_in, .prog_busy);

// [sim/iesp_master.sv]
// iesp_master: behavioural i2c bus master for the eeprom target engine
// assumes an outside pull-up on sda; scl is push-pull and idles high
module iesp_master (
    // serial link
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // **********
    // bus cycles
    // **********
    task automatic bit_io(input logic b, output logic r);
        #20 sda_low = !b;
        #100 scl = 1'b1;
        #40 r = sda;
        scl = 1'b0;
    endtask : bit_io
    task automatic start();
        // low phase outlasts the target's release latency, else a false stop
        sda_low = 1'b0;
        #140 scl = 1'b1;
        #120 sda_low = 1'b1;
        #120 scl = 1'b0;
    endtask : start
    task automatic stop();
        #20 sda_low = 1'b1;
        #100 scl = 1'b1;
        #120 sda_low = 1'b0;
        #200;
    endtask : stop
    task automatic byte_tx(input logic [7:0] v, output logic ak);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(v[i], r);
        end
        bit_io(1'b1, r);
        ak = !r;
    endtask : byte_tx
    task automatic byte_rx(input logic mack, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, v[i]);
        end
        bit_io(!mack, r);
    endtask : byte_rx
endmodule : iesp_master
